// >>> hdl/pir_periph_irq.sv
// Interrupt request flags, enables and flag-clear sequences for the
// core timer, programmable timer, serial interface and analog comparators.
// Assumes peripheral events arrive as one-cycle pulses synchronous to i_clk
// and that the CPU interrupt mask bit is a level on i_cpu_imask.
//
// Overview of operation
// - CPU mask bit blocks every request output
// - Core overflow flag and enable raise request
// - Write-one or reset clears core overflow flag
// - Periodic tick flag and enable raise request
// - Write-one or reset clears periodic tick flag
// - Capture flag and enable raise timer request
// - Capture flag clears: status read, capture-low read
// - Reset leaves timer interrupt enables untouched
// - Compare flag and enable raise timer request
// - Compare flag clears: status read, compare-low access
// - Timer overflow flag and enable raise request
// - Overflow flag clears: status read, counter-low access
// - Serial completion flag and enable raise request
// - Serial flag clears: status read, data access
// - Serial clear bit write-one clears completion flag
// - Either comparator flag with enable raises request
// - Write-one clears comparator flags; reset clears both
// - Comparator two with capture enable forces capture
`timescale 1ns/1ps

module pir_periph_irq (
    input  wire logic                      i_clk,            // Bus clock, 200 MHz
    input  wire logic                      i_sys_rst,        // Sync reset, active high
    input  wire logic [pir_pkg::PIR_AW-1:0] i_addr,          // Register address
    input  wire logic [pir_pkg::PIR_DW-1:0] i_wdata,         // Write data
    input  wire logic                      i_wr,             // Write strobe
    input  wire logic                      i_rd,             // Read strobe
    output logic      [pir_pkg::PIR_DW-1:0] o_rdata,         // Read data, next cycle
    input  wire logic                      i_core_ovf_evt,   // Core counter wrapped
    input  wire logic                      i_tick_evt,       // Periodic tick elapsed
    input  wire logic                      i_cap_pin_evt,    // Capture edge on pin
    input  wire logic                      i_cmp_match_evt,  // Output compare match
    input  wire logic                      i_cnt_ovf_evt,    // Timer counter wrapped
    input  wire logic                      i_xfer_done_evt,  // Serial transfer done
    input  wire logic                      i_cmp1_evt,       // Comparator one tripped
    input  wire logic                      i_cmp2_evt,       // Comparator two tripped
    input  wire logic                      i_cpu_imask,      // CPU interrupt mask bit
    output logic                           o_core_timer_irq, // Core timer request
    output logic                           o_prog_timer_irq, // Programmable timer request
    output logic                           o_serial_irq,     // Serial request
    output logic                           o_analog_irq,     // Comparator request
    output logic                           o_capture_trig    // Capture pulse to timer
);
    import pir_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic wr_core_timer_status_control;
    logic wr_scr;
    logic wr_tcr;
    logic wr_acr;
    logic wr_asr;
    logic wr_sdr;
    logic rd_tsr;
    logic rd_ssr;
    logic sdr_access;
    logic [PIR_NTMR-1:0] tstep2;
    logic [PIR_NTMR-1:0] tset;

    assign wr_core_timer_status_control   = i_wr && (i_addr == PIR_CORE_TIMER_STATUS_CONTROL_ADDR);
    assign wr_scr     = i_wr && (i_addr == PIR_SCR_ADDR);
    assign wr_tcr     = i_wr && (i_addr == PIR_TCR_ADDR);
    assign wr_acr     = i_wr && (i_addr == PIR_ACR_ADDR);
    assign wr_asr     = i_wr && (i_addr == PIR_ASR_ADDR);
    assign wr_sdr     = i_wr && (i_addr == PIR_SDR_ADDR);
    assign rd_tsr     = i_rd && (i_addr == PIR_TSR_ADDR);
    assign rd_ssr     = i_rd && (i_addr == PIR_SSR_ADDR);
    assign sdr_access = (i_wr || i_rd) && (i_addr == PIR_SDR_ADDR);

    // Second step of each timer clear: capture low is read-only here
    assign tstep2[PIR_T_CAP] = i_rd && (i_addr == PIR_CAPL_ADDR);
    assign tstep2[PIR_T_CMP] = (i_rd || i_wr) && (i_addr == PIR_CMPL_ADDR);
    assign tstep2[PIR_T_OVF] = (i_rd || i_wr) && (i_addr == PIR_CNTL_ADDR);

    // ------------------------------------------------------------------
    // Core timer flags and enables
    // ------------------------------------------------------------------
    logic ovf_flag_reg;
    logic tick_flag_reg;
    logic ovf_ie_reg;
    logic tick_ie_reg;

    // Flags: a new event wins over a same-cycle clear so none is lost
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ovf_flag_reg  <= 1'b0;
            tick_flag_reg <= 1'b0;
        end else begin
            if (i_core_ovf_evt) begin
                ovf_flag_reg <= 1'b1;
            end else if (wr_core_timer_status_control && i_wdata[PIR_CT_OVF_CLR]) begin
                ovf_flag_reg <= 1'b0;
            end
            if (i_tick_evt) begin
                tick_flag_reg <= 1'b1;
            end else if (wr_core_timer_status_control && i_wdata[PIR_CT_TICK_CLR]) begin
                tick_flag_reg <= 1'b0;
            end
        end
    end

    // Core timer enables, cleared by reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ovf_ie_reg  <= 1'b0;
            tick_ie_reg <= 1'b0;
        end else if (wr_core_timer_status_control) begin
            ovf_ie_reg  <= i_wdata[PIR_CT_OVF_IE];
            tick_ie_reg <= i_wdata[PIR_CT_TICK_IE];
        end
    end

    // ------------------------------------------------------------------
    // Analog control and comparator flags
    // ------------------------------------------------------------------
    logic [PIR_DW-1:0] acr_reg;
    logic              cmp1_flag_reg;
    logic              cmp2_flag_reg;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            acr_reg <= PIR_ZERO;
        end else if (wr_acr) begin
            acr_reg <= i_wdata;
        end
    end

    // Comparator flags; set wins over write-one clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmp1_flag_reg <= 1'b0;
            cmp2_flag_reg <= 1'b0;
        end else begin
            if (i_cmp1_evt) begin
                cmp1_flag_reg <= 1'b1;
            end else if (wr_asr && i_wdata[PIR_ASR_CLR1]) begin
                cmp1_flag_reg <= 1'b0;
            end
            if (i_cmp2_evt) begin
                cmp2_flag_reg <= 1'b1;
            end else if (wr_asr && i_wdata[PIR_ASR_CLR2]) begin
                cmp2_flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Programmable timer flags, two-step clear, enables
    // ------------------------------------------------------------------
    logic [PIR_NTMR-1:0] tflag_reg;
    logic [PIR_NTMR-1:0] tarm_reg;
    logic [PIR_NTMR-1:0] ten_reg;
    logic                edge_sel_reg;
    logic [PIR_DW-1:0]   tsr_view;
    logic [PIR_DW-1:0]   tcr_view;

    // Comparator two doubles as a capture source when enabled
    assign tset[PIR_T_CAP] = i_cap_pin_evt || (i_cmp2_evt && acr_reg[PIR_ACR_CAPEN]);
    assign tset[PIR_T_CMP] = i_cmp_match_evt;
    assign tset[PIR_T_OVF] = i_cnt_ovf_evt;

    genvar gi;
    generate
        for (gi = 0; gi < PIR_NTMR; gi++) begin : g_tmr
            // Status read with the flag set arms the clear; second access fires it
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    tflag_reg[gi] <= 1'b0;
                    tarm_reg[gi]  <= 1'b0;
                end else begin
                    if (tset[gi]) begin
                        tflag_reg[gi] <= 1'b1;
                    end else if (tarm_reg[gi] && tstep2[gi]) begin
                        tflag_reg[gi] <= 1'b0;
                    end
                    if (rd_tsr && tflag_reg[gi]) begin
                        tarm_reg[gi] <= 1'b1;
                    end else if (tstep2[gi]) begin
                        tarm_reg[gi] <= 1'b0;
                    end
                end
            end

            // Enables deliberately have no reset term
            always_ff @(posedge i_clk) begin
                if (wr_tcr) begin
                    ten_reg[gi] <= i_wdata[PIR_T_TOP-gi];
                end
            end

            assign tsr_view[PIR_T_TOP-gi] = tflag_reg[gi];
            assign tcr_view[PIR_T_TOP-gi] = ten_reg[gi];
        end
    endgenerate

    assign tsr_view[PIR_T_TOP-PIR_NTMR:0] = '0;
    assign tcr_view[PIR_T_TOP-PIR_NTMR:PIR_TCR_EDGE+1] = '0;
    assign tcr_view[PIR_TCR_EDGE] = edge_sel_reg;
    assign tcr_view[PIR_TCR_EDGE-1:0] = '0;

    // Edge select also survives reset; capture via comparator does not depend on it
    always_ff @(posedge i_clk) begin
        if (wr_tcr) begin
            edge_sel_reg <= i_wdata[PIR_TCR_EDGE];
        end
    end

    // ------------------------------------------------------------------
    // Serial interface flag, clears and data
    // ------------------------------------------------------------------
    logic              ser_flag_reg;
    logic              ser_arm_reg;
    logic              ser_ie_reg;
    logic              ser_en_reg;
    logic [PIR_DW-1:0] sdr_reg;

    // Either clear path loses to a completion in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ser_flag_reg <= 1'b0;
            ser_arm_reg  <= 1'b0;
        end else begin
            if (i_xfer_done_evt) begin
                ser_flag_reg <= 1'b1;
            end else if (ser_arm_reg && sdr_access) begin
                ser_flag_reg <= 1'b0;
            end else if (wr_scr && i_wdata[PIR_SCR_CLR]) begin
                ser_flag_reg <= 1'b0;
            end
            if (rd_ssr && ser_flag_reg) begin
                ser_arm_reg <= 1'b1;
            end else if (sdr_access) begin
                ser_arm_reg <= 1'b0;
            end
        end
    end

    // Serial control, cleared by reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ser_ie_reg <= 1'b0;
            ser_en_reg <= 1'b0;
        end else if (wr_scr) begin
            ser_ie_reg <= i_wdata[PIR_SCR_IE];
            ser_en_reg <= i_wdata[PIR_SCR_EN];
        end
    end

    // Data register keeps its contents through reset
    always_ff @(posedge i_clk) begin
        if (wr_sdr) begin
            sdr_reg <= i_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Request outputs
    // ------------------------------------------------------------------
    logic core_req;
    logic tmr_req;
    logic ser_req;
    logic ana_req;

    assign core_req = (ovf_flag_reg && ovf_ie_reg)
                   || (tick_flag_reg && tick_ie_reg);
    assign tmr_req  = (tflag_reg[PIR_T_CAP] && ten_reg[PIR_T_CAP])
                   || (tflag_reg[PIR_T_CMP] && ten_reg[PIR_T_CMP])
                   || (tflag_reg[PIR_T_OVF] && ten_reg[PIR_T_OVF]);
    assign ser_req  = ser_flag_reg && ser_ie_reg;
    assign ana_req  = (cmp1_flag_reg || cmp2_flag_reg) && acr_reg[PIR_ACR_IE];

    // Registered for clean outputs; costs one cycle of latency
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_core_timer_irq <= 1'b0;
            o_prog_timer_irq <= 1'b0;
            o_serial_irq     <= 1'b0;
            o_analog_irq     <= 1'b0;
        end else begin
            o_core_timer_irq <= core_req && !i_cpu_imask;
            o_prog_timer_irq <= tmr_req && !i_cpu_imask;
            o_serial_irq     <= ser_req && !i_cpu_imask;
            o_analog_irq     <= ana_req && !i_cpu_imask;
        end
    end

    // Capture strobe to the timer datapath when comparator two trips with capture enabled
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_capture_trig <= 1'b0;
        end else begin
            o_capture_trig <= i_cmp2_evt && acr_reg[PIR_ACR_CAPEN];
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [PIR_DW-1:0] rdata_next;

    // Unmapped addresses and idle cycles return zero
    always_comb begin
        rdata_next = PIR_ZERO;
        if (i_rd) begin
            unique case (i_addr)
                PIR_CORE_TIMER_STATUS_CONTROL_ADDR: begin
                    rdata_next[PIR_CT_OVF_FLAG]  = ovf_flag_reg;
                    rdata_next[PIR_CT_TICK_FLAG] = tick_flag_reg;
                    rdata_next[PIR_CT_OVF_IE]    = ovf_ie_reg;
                    rdata_next[PIR_CT_TICK_IE]   = tick_ie_reg;
                end
                PIR_SCR_ADDR: begin
                    rdata_next[PIR_SCR_IE] = ser_ie_reg;
                    rdata_next[PIR_SCR_EN] = ser_en_reg;
                end
                PIR_SSR_ADDR: rdata_next[PIR_SSR_FLAG] = ser_flag_reg;
                PIR_SDR_ADDR: rdata_next = sdr_reg;
                PIR_TCR_ADDR: rdata_next = tcr_view;
                PIR_TSR_ADDR: rdata_next = tsr_view;
                PIR_ACR_ADDR: rdata_next = acr_reg;
                PIR_ASR_ADDR: begin
                    rdata_next[PIR_ASR_CMP2] = cmp2_flag_reg;
                    rdata_next[PIR_ASR_CMP1] = cmp1_flag_reg;
                end
                default: rdata_next = PIR_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= PIR_ZERO;
        end else begin
            o_rdata <= rdata_next;
        end
    end

endmodule

// >>> hdl/pir_pkg.sv
// Constants for the peripheral interrupt request block: register map,
// bit positions and reset values.
// Assumes an 8-bit register port with byte-wide addresses.
package pir_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int PIR_AW = 8;
    localparam int PIR_DW = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [PIR_AW-1:0] PIR_CORE_TIMER_STATUS_CONTROL_ADDR = 8'h08;  // core_timer_status_control
    localparam logic [PIR_AW-1:0] PIR_SCR_ADDR   = 8'h0A;  // serial_control
    localparam logic [PIR_AW-1:0] PIR_SSR_ADDR   = 8'h0B;  // serial_status
    localparam logic [PIR_AW-1:0] PIR_SDR_ADDR   = 8'h0C;  // serial_data
    localparam logic [PIR_AW-1:0] PIR_TCR_ADDR   = 8'h12;  // timer_control
    localparam logic [PIR_AW-1:0] PIR_TSR_ADDR   = 8'h13;  // timer_status
    localparam logic [PIR_AW-1:0] PIR_CAPL_ADDR  = 8'h15;  // capture_register_low
    localparam logic [PIR_AW-1:0] PIR_CMPL_ADDR  = 8'h17;  // compare_register_low
    localparam logic [PIR_AW-1:0] PIR_CNTL_ADDR  = 8'h19;  // counter_low_byte
    localparam logic [PIR_AW-1:0] PIR_ACR_ADDR   = 8'h1D;  // analog_control
    localparam logic [PIR_AW-1:0] PIR_ASR_ADDR   = 8'h1E;  // analog_status

    // ------------------------------------------------------------------
    // Core timer status/control bits
    // ------------------------------------------------------------------
    localparam int PIR_CT_OVF_FLAG  = 7;
    localparam int PIR_CT_TICK_FLAG = 6;
    localparam int PIR_CT_OVF_IE    = 5;
    localparam int PIR_CT_TICK_IE   = 4;
    localparam int PIR_CT_OVF_CLR   = 3;
    localparam int PIR_CT_TICK_CLR  = 2;

    // ------------------------------------------------------------------
    // Programmable timer: index 0 capture, 1 compare, 2 overflow;
    // flag and enable of index i sit at bit PIR_T_TOP - i
    // ------------------------------------------------------------------
    localparam int PIR_NTMR  = 3;
    localparam int PIR_T_CAP = 0;
    localparam int PIR_T_CMP = 1;
    localparam int PIR_T_OVF = 2;
    localparam int PIR_T_TOP = 7;
    localparam int PIR_TCR_EDGE = 1;

    // ------------------------------------------------------------------
    // Serial and analog bits
    // ------------------------------------------------------------------
    localparam int PIR_SCR_IE   = 7;
    localparam int PIR_SCR_EN   = 6;
    localparam int PIR_SCR_CLR  = 3;
    localparam int PIR_SSR_FLAG = 7;
    localparam int PIR_ACR_IE   = 7;
    localparam int PIR_ACR_CAPEN = 6;
    localparam int PIR_ASR_CMP2 = 7;
    localparam int PIR_ASR_CMP1 = 6;
    localparam int PIR_ASR_CLR2 = 1;
    localparam int PIR_ASR_CLR1 = 0;

    localparam logic [PIR_DW-1:0] PIR_ZERO = 8'h00;

endpackage

// >>> testbench/pir_cpu_model.sv
// CPU-side model: owns the interrupt mask bit and notes taken requests.
// Assumes the bench steers the mask through i_mask_req.
`timescale 1ns/1ps

module pir_cpu_model (
    input  wire logic       i_clk,      // Clock
    input  wire logic       i_sys_rst,  // Reset
    input  wire logic       i_mask_req, // Mask wanted by software
    input  wire logic [3:0] i_irq,      // Request lines
    output logic            o_imask,    // Mask bit to the block
    output logic            o_seen      // A request reached the core
);
    // Reset sets the mask, so nothing is taken before software is ready
    assign o_imask = i_sys_rst | i_mask_req;

    // Sticky note of any request seen unmasked
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) o_seen <= 1'h0;
        else if (|i_irq && !o_imask) o_seen <= 1'h1;
    end
endmodule

// >>> testbench/pir_periph_irq_checker.sv
// Assertion checker for the peripheral interrupt request block.
// Sees only the top ports; enable bits are mirrored from bus writes.
`timescale 1ns/1ps

module pir_periph_irq_checker (
    input wire logic                       i_clk,            // Clock
    input wire logic                       i_sys_rst,        // Reset
    input wire logic [pir_pkg::PIR_AW-1:0] i_addr,           // Address
    input wire logic [pir_pkg::PIR_DW-1:0] i_wdata,          // Write data
    input wire logic                       i_wr,             // Write strobe
    input wire logic                       i_rd,             // Read strobe
    input wire logic [pir_pkg::PIR_DW-1:0] o_rdata,          // Read data
    input wire logic                       i_core_ovf_evt,   // Core overflow
    input wire logic                       i_tick_evt,       // Tick
    input wire logic                       i_cap_pin_evt,    // Pin capture
    input wire logic                       i_cmp_match_evt,  // Compare match
    input wire logic                       i_cnt_ovf_evt,    // Timer overflow
    input wire logic                       i_xfer_done_evt,  // Serial done
    input wire logic                       i_cmp1_evt,       // Comparator one
    input wire logic                       i_cmp2_evt,       // Comparator two
    input wire logic                       i_cpu_imask,      // Mask bit
    input wire logic                       o_core_timer_irq, // Core request
    input wire logic                       o_prog_timer_irq, // Timer request
    input wire logic                       o_serial_irq,     // Serial request
    input wire logic                       o_analog_irq,     // Analog request
    input wire logic                       o_capture_trig    // Capture pulse
);
    import pir_pkg::*;

    logic [7:0] ct_reg;   // Mirrored core timer controls
    logic [7:0] acr_reg;  // Mirrored analog controls
    logic       any_irq;  // Any request line

    // Mirrors follow writes; reset clears both, as in the block
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ct_reg  <= PIR_ZERO;
            acr_reg <= PIR_ZERO;
        end else if (i_wr) begin
            if (i_addr == PIR_CORE_TIMER_STATUS_CONTROL_ADDR) ct_reg <= i_wdata;
            if (i_addr == PIR_ACR_ADDR) acr_reg <= i_wdata;
        end
    end
    assign any_irq = o_core_timer_irq | o_prog_timer_irq | o_serial_irq | o_analog_irq;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    mask_blocks_a: assert property (i_cpu_imask |=> !any_irq)
        else $error("request present while masked");
    core_raise_a: assert property (
        i_core_ovf_evt ##1 (ct_reg[PIR_CT_OVF_IE] && !i_cpu_imask) |=> o_core_timer_irq)
        else $error("core overflow request missing");
    core_clear_a: assert property (
        i_wr && i_addr == PIR_CORE_TIMER_STATUS_CONTROL_ADDR && i_wdata[PIR_CT_OVF_CLR] && i_wdata[PIR_CT_TICK_CLR]
        && !i_core_ovf_evt && !i_tick_evt |=> ##1 !o_core_timer_irq)
        else $error("core request left after clear");
    serial_clear_a: assert property (
        i_wr && i_addr == PIR_SCR_ADDR && i_wdata[PIR_SCR_CLR] && !i_xfer_done_evt
        |=> ##1 !o_serial_irq) else $error("serial request left after clear");
    serial_drop_a: assert property (
        i_wr && i_addr == PIR_SCR_ADDR && !i_wdata[PIR_SCR_IE] |=> ##1 !o_serial_irq)
        else $error("serial request left after disable");
    analog_raise_a: assert property (
        (i_cmp1_evt || i_cmp2_evt) ##1 (acr_reg[PIR_ACR_IE] && !i_cpu_imask) |=> o_analog_irq)
        else $error("comparator request missing");
    analog_clear_a: assert property (
        i_wr && i_addr == PIR_ASR_ADDR && i_wdata[PIR_ASR_CLR1] && i_wdata[PIR_ASR_CLR2]
        && !i_cmp1_evt && !i_cmp2_evt |=> ##1 !o_analog_irq)
        else $error("comparator request left after clear");
    capture_trig_a: assert property (
        i_cmp2_evt && acr_reg[PIR_ACR_CAPEN] |=> o_capture_trig)
        else $error("capture pulse missing");
endmodule

bind pir_periph_irq pir_periph_irq_checker i_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_ovf_evt(i_core_ovf_evt),
    .i_tick_evt(i_tick_evt), .i_cap_pin_evt(i_cap_pin_evt),
    .i_cmp_match_evt(i_cmp_match_evt), .i_cnt_ovf_evt(i_cnt_ovf_evt),
    .i_xfer_done_evt(i_xfer_done_evt), .i_cmp1_evt(i_cmp1_evt), .i_cmp2_evt(i_cmp2_evt),
    .i_cpu_imask(i_cpu_imask), .o_core_timer_irq(o_core_timer_irq),
    .o_prog_timer_irq(o_prog_timer_irq), .o_serial_irq(o_serial_irq),
    .o_analog_irq(o_analog_irq), .o_capture_trig(o_capture_trig)
);

// >>> testbench/pir_periph_irq_tb_top.sv
// Self-checking bench for the peripheral interrupt request block.
// Assumes read data one cycle after the strobe and registered requests.
`timescale 1ns/1ps

module pir_periph_irq_tb_top;
    import pir_pkg::*;
    logic        i_clk = 1'h0;
    logic        i_sys_rst = 1'h1;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'h0;
    logic        i_rd = 1'h0;
    logic [7:0]  evt = 8'h00;   // ovf, tick, cap, cmp, cnt, xfer, c1, c2
    logic        mask_req = 1'h0;
    logic        rd_d = 1'h0;
    logic        imask, trig, seen;
    logic [7:0]  o_rdata;
    logic [3:0]  irq;           // core, timer, serial, analog
    logic [7:0]  exp_q[$];
    logic [7:0]  step2[3] = '{PIR_CAPL_ADDR, PIR_CMPL_ADDR, PIR_CNTL_ADDR};
    logic [31:0] seed = 32'h00013732;
    int          failures = 0;
    int          num_checks = 0;

    always #2.5 i_clk = ~i_clk;

    pir_periph_irq i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core_ovf_evt(evt[0]),
        .i_tick_evt(evt[1]), .i_cap_pin_evt(evt[2]), .i_cmp_match_evt(evt[3]),
        .i_cnt_ovf_evt(evt[4]), .i_xfer_done_evt(evt[5]), .i_cmp1_evt(evt[6]),
        .i_cmp2_evt(evt[7]), .i_cpu_imask(imask), .o_core_timer_irq(irq[3]),
        .o_prog_timer_irq(irq[2]), .o_serial_irq(irq[1]), .o_analog_irq(irq[0]),
        .o_capture_trig(trig)
    );
    pir_cpu_model i_cpu (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mask_req(mask_req), .i_irq(irq),
        .o_imask(imask), .o_seen(seen)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] e);
        num_checks++;
        if (got !== e) begin
            failures++;
            $display("mismatch at %0t: read %h, expected %h", $time, got, e);
        end
    endtask
    task automatic cmp_irq(input logic [3:0] e);
        num_checks++;
        if (irq !== e) begin
            failures++;
            $display("mismatch at %0t: requests %b, expected %b", $time, irq, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'h1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask
    // Expected data noted before the strobe; the monitor pops it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        i_rd <= 1'h1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'h0;
    endtask
    task automatic pulse(input int n);
        @(posedge i_clk);
        evt[n] <= 1'h1;
        @(posedge i_clk);
        evt[n] <= 1'h0;
    endtask
    // Requests are flops: look one edge after the cause has landed
    task automatic chk(input logic [3:0] e);
        @(posedge i_clk);
        @(negedge i_clk);
        cmp_irq(e);
    endtask
    task automatic complete_run();
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Read monitor: data stands only in the cycle after the strobe
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) begin
        if (rd_d && exp_q.size() > 0) cmp_rd(o_rdata, exp_q.pop_front());
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'h0;
        rd(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'h00);
        rd(PIR_TSR_ADDR, 8'h00);
        rd(PIR_ASR_ADDR, 8'h00);
        rd(8'h01, 8'h00);
        wr(8'h01, 8'hFF);
        seed = xs(seed);
        wr(PIR_SDR_ADDR, seed[7:0]);
        rd(PIR_SDR_ADDR, seed[7:0]);
        wr(PIR_TCR_ADDR, 8'hE2);
        rd(PIR_TCR_ADDR, 8'hE2);
        wr(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'h30);
        pulse(0);
        chk(4'h8);
        rd(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'hB0);
        mask_req <= 1'h1;
        chk(4'h0);
        mask_req <= 1'h0;
        chk(4'h8);
        wr(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'h38);
        chk(4'h0);
        pulse(1);
        chk(4'h8);
        wr(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'h3C);
        chk(4'h0);
        for (int k = 0; k < 3; k++) begin
            pulse(2 + k);
            chk(4'h4);
            rd(step2[k], 8'h00);
            chk(4'h4);
            rd(PIR_TSR_ADDR, 8'h80 >> k);
            if (k == 1) wr(step2[k], seed[15:8]);
            else rd(step2[k], 8'h00);
            chk(4'h0);
        end
        wr(PIR_SCR_ADDR, 8'h80);
        pulse(5);
        chk(4'h2);
        rd(PIR_SSR_ADDR, 8'h80);
        wr(PIR_SDR_ADDR, 8'h5A);
        chk(4'h0);
        pulse(5);
        wr(PIR_SCR_ADDR, 8'h88);
        chk(4'h0);
        rd(PIR_SCR_ADDR, 8'h80);
        pulse(5);
        chk(4'h2);
        wr(PIR_SCR_ADDR, 8'h00);
        chk(4'h0);
        wr(PIR_ACR_ADDR, 8'h80);
        for (int k = 0; k < 2; k++) begin
            pulse(6 + k);
            chk(4'h1);
            rd(PIR_ASR_ADDR, 8'h40 << k);
            wr(PIR_ASR_ADDR, 8'h01 << k);
            chk(4'h0);
        end
        wr(PIR_ACR_ADDR, 8'hC0);
        pulse(7);
        @(negedge i_clk) cmp_rd({6'h00, trig, seen}, 8'h03);
        repeat (3) @(posedge i_clk);
        chk(4'h5);
        rd(PIR_TSR_ADDR, 8'h80);
        rd(PIR_CAPL_ADDR, 8'h00);
        wr(PIR_ASR_ADDR, 8'h03);
        chk(4'h0);
        wr(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'h30);
        pulse(0);
        i_sys_rst <= 1'h1;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'h0;
        rd(PIR_TCR_ADDR, 8'hE2);
        rd(PIR_CORE_TIMER_STATUS_CONTROL_ADDR, 8'h00);
        complete_run();
    end
endmodule
